/* File: gcid_regs.sv */
// gcid_regs: identity and general configuration registers behind the serial
// port, master timing from the 32.768 kHz source, channel and lead-off control.
// assumes: serial pins and comparators are asynchronous, source clock << 50 MHz.
module gcid_regs #(
  parameter logic [3:0] SILICON_REVISION = 4'h3,  // arbitrary value
  parameter logic [1:0] PART_IDENT       = 2'h2   // arbitrary value
) (
  input  wire logic                   CLOCK_IN,             // 50 MHz system clock
  input  wire logic                   RESETN_IN,            // synchronous reset, active low
  input  wire logic                   CE_IN,                // clock enable, freezes state when low
  input  wire logic                   SPI_CSB_N_IN,         // serial chip select, active low
  input  wire logic                   SPI_SCLK_IN,          // serial clock pin
  input  wire logic                   SPI_SDI_IN,           // serial data in
  output logic                        SPI_SDO_OUT,          // serial data out
  output logic                        SPI_SDO_OE_OUT,       // serial data out enable
  input  wire logic                   SOURCE_CLOCK_32K_IN,  // fixed 32.768 kHz source
  input  wire logic                   IMP_OVER_CMP_IN,      // impedance over-range compare
  input  wire logic                   IMP_UNDER_CMP_IN,     // impedance under-range compare
  input  wire logic                   DC_LEADOFF_CMP_IN,    // dc lead-off compare
  output gcid_pkg::gcid_chan_type     CHANNEL_CTRL_OUT,     // channel and current control
  output gcid_pkg::gcid_flag_type     EVENT_FLAGS_OUT,      // gated lead-off event flags
  output logic                        MASTER_TICK_OUT,      // one pulse per master clock
  output logic                        PROGRESSION_TICK_OUT, // cardiac progression pulse
  output logic                        SYNC_RESTART_OUT      // restart pulse after synchronize
);
  import gcid_pkg::*;

  typedef struct packed {
    logic           sel_s1;
    logic           sel_s2;
    logic           sclk_s1;
    logic           sclk_s2;
    logic           sclk_d;
    logic           sdi_s1;
    logic           sdi_s2;
    logic           src_s1;
    logic           src_s2;
    logic           src_d;
    logic [2:0]     cmp_s1;
    logic [2:0]     cmp_s2;
    gcid_phase_type phase;
    logic [5:0]     bit_cnt;
    logic [30:0]    shift_in;
    logic [23:0]    shift_out;
    logic           sdo;
    gcid_gen_type   gen;
    logic           init_done;
    logic           sync_pend;
    logic           sync_pulse;
    logic [7:0]     acc;
    logic [7:0]     prog_cnt;
    logic           mtick;
    logic           ptick;
    gcid_chan_type  chan;
    gcid_flag_type  flags;
  } gcid_state_type;

  gcid_state_type st_r;
  gcid_state_type st_nxt;

  logic        sclk_rise;
  logic        sclk_fall;
  logic        src_edge;
  logic        end_now;
  logic [6:0]  addr_now;
  logic [23:0] read_word;
  logic [6:0]  wr_addr;
  logic        wr_rw;
  logic [23:0] wr_data;
  logic [23:0] wr_masked;
  logic [7:0]  ratio_num;
  logic [7:0]  ratio_den;
  logic [7:0]  prog_div;
  logic [8:0]  acc_sum;
  logic        tick_now;

  function automatic logic [23:0] read_value(input logic [6:0] addr, input logic done,
                                             input gcid_gen_type gen);
    logic [23:0] v;
    v = 24'h00_0000;
    case (addr)
      ADDR_IDENTITY: begin
        if (done) begin
          v = {ID_PATTERN, SILICON_REVISION, 2'h0, PART_IDENT, ID_LOW_ZERO};
        end
      end
      ADDR_GENERAL:  v = gen & GEN_WRITE_MASK;
      default:       v = 24'h00_0000;
    endcase
    return v;
  endfunction : read_value

  assign sclk_rise = st_r.sclk_s2 & ~st_r.sclk_d;
  assign sclk_fall = ~st_r.sclk_s2 & st_r.sclk_d;
  assign src_edge  = st_r.src_s2 & ~st_r.src_d;
  assign end_now   = st_r.sel_s2 & sclk_rise & (st_r.phase == SPI_DATA) & (st_r.bit_cnt == LAST_FRAME_BIT);
  assign addr_now  = st_r.shift_in[6:0];
  assign read_word = read_value(addr_now, st_r.init_done, st_r.gen);
  assign wr_addr   = st_r.shift_in[30:24];
  assign wr_rw     = st_r.shift_in[23];
  assign wr_data   = {st_r.shift_in[22:0], st_r.sdi_s2};
  assign wr_masked = wr_data & GEN_WRITE_MASK;

  // master clock ratio and progression length per timing select
  always_comb begin
    case (st_r.gen.master_timing_select)
      MSTR_32768: begin
        ratio_num = RATIO_FULL;
        ratio_den = RATIO_FULL;
        prog_div  = PROG_DIV_FAST;
      end
      MSTR_32000_500: begin
        ratio_num = RATIO_32000_NUM;
        ratio_den = RATIO_32000_DEN;
        prog_div  = PROG_DIV_FAST;
      end
      MSTR_32000_200: begin
        ratio_num = RATIO_32000_NUM;
        ratio_den = RATIO_32000_DEN;
        prog_div  = PROG_DIV_SLOW;
      end
      default: begin
        ratio_num = RATIO_31968_NUM;
        ratio_den = RATIO_31968_DEN;
        prog_div  = PROG_DIV_SLOW;
      end
    endcase
  end

  assign acc_sum  = {1'b0, st_r.acc} + {1'b0, ratio_num};
  assign tick_now = src_edge & (acc_sum >= {1'b0, ratio_den});

  always_comb begin
    st_nxt = st_r;
    st_nxt.sel_s1  = ~SPI_CSB_N_IN;
    st_nxt.sel_s2  = st_r.sel_s1;
    st_nxt.sclk_s1 = SPI_SCLK_IN;
    st_nxt.sclk_s2 = st_r.sclk_s1;
    st_nxt.sclk_d  = st_r.sclk_s2;
    st_nxt.sdi_s1  = SPI_SDI_IN;
    st_nxt.sdi_s2  = st_r.sdi_s1;
    st_nxt.src_s1  = SOURCE_CLOCK_32K_IN;
    st_nxt.src_s2  = st_r.src_s1;
    st_nxt.src_d   = st_r.src_s2;
    st_nxt.cmp_s1  = {IMP_OVER_CMP_IN, IMP_UNDER_CMP_IN, DC_LEADOFF_CMP_IN};
    st_nxt.cmp_s2  = st_r.cmp_s1;
    st_nxt.mtick      = 1'b0;
    st_nxt.ptick      = 1'b0;
    st_nxt.sync_pulse = 1'b0;

    // master timing: fractional divide of the source edges
    if (src_edge) begin
      if (tick_now) begin
        st_nxt.acc = 8'(acc_sum - {1'b0, ratio_den});
      end else begin
        st_nxt.acc = acc_sum[7:0];
      end
    end
    if (tick_now) begin
      st_nxt.mtick = 1'b1;
      if (st_r.sync_pend) begin
        st_nxt.sync_pulse = 1'b1;
        st_nxt.sync_pend  = 1'b0;
        st_nxt.prog_cnt   = 8'h00;
      end else if (st_r.prog_cnt >= 8'(prog_div - 8'h01)) begin
        st_nxt.prog_cnt = 8'h00;
        st_nxt.ptick    = st_r.gen.cardiac_channel_enable;
      end else begin
        st_nxt.prog_cnt = st_r.prog_cnt + 8'h01;
      end
    end

    // serial frame: address byte, then 24 data bits, msb first
    if (!st_r.sel_s2) begin
      st_nxt.phase   = SPI_IDLE;
      st_nxt.bit_cnt = 6'h00;
    end else if (sclk_rise) begin
      st_nxt.shift_in = {st_r.shift_in[29:0], st_r.sdi_s2};
      st_nxt.bit_cnt  = st_r.bit_cnt + 6'h01;
      case (st_r.phase)
        SPI_IDLE, SPI_ADDR: begin
          st_nxt.phase = SPI_ADDR;
          if (st_r.bit_cnt == LAST_ADDR_BIT) begin
            st_nxt.phase     = SPI_DATA;
            st_nxt.shift_out = st_r.sdi_s2 ? read_word : 24'h00_0000;
          end
        end
        SPI_DATA: begin
          if (st_r.bit_cnt == LAST_FRAME_BIT) begin
            st_nxt.phase = SPI_DONE;
          end
        end
        default: st_nxt.phase = SPI_DONE;
      endcase
    end else if (sclk_fall && st_r.phase == SPI_DATA) begin
      st_nxt.sdo       = st_r.shift_out[23];
      st_nxt.shift_out = {st_r.shift_out[22:0], 1'b0};
    end

    // command execution on the last rising edge of the frame
    if (end_now) begin
      st_nxt.init_done = 1'b1;
      if (!wr_rw) begin
        case (wr_addr)
          ADDR_GENERAL: st_nxt.gen = gcid_gen_type'(wr_masked);
          ADDR_SYNC: begin
            if (wr_data == 24'h00_0000) begin
              st_nxt.sync_pend = 1'b1;
            end
          end
          ADDR_SW_RESET: begin
            if (wr_data == 24'h00_0000) begin
              st_nxt.gen       = gcid_gen_type'(GEN_RESET);
              st_nxt.init_done = 1'b0;
              st_nxt.sync_pend = 1'b0;
            end
          end
          default: st_nxt.init_done = 1'b1;
        endcase
      end
    end

    // channel control decoded from the next configuration
    st_nxt.chan.cardiac_on   = st_nxt.gen.cardiac_channel_enable;
    st_nxt.chan.impedance_on = st_nxt.gen.impedance_channel_enable;
    st_nxt.chan.pace_on      = st_nxt.gen.pace_channel_enable & st_nxt.gen.cardiac_channel_enable;
    st_nxt.chan.lowpower_mode = ~st_nxt.gen.cardiac_channel_enable
                                & ~st_nxt.gen.impedance_channel_enable;
    st_nxt.chan.leadon_detect_on = ~st_nxt.gen.cardiac_channel_enable
                                   & (st_nxt.gen.lowpower_leadon_enable == ULP_CARDIAC);
    st_nxt.chan.master_timing_select     = st_nxt.gen.master_timing_select;
    st_nxt.chan.leadoff_current_polarity = st_nxt.gen.leadoff_current_polarity;
    st_nxt.chan.leadoff_current_magnitude = st_nxt.gen.leadoff_current_magnitude;
    st_nxt.chan.leadoff_connect = st_nxt.gen.cardiac_channel_enable
                                  & (st_nxt.gen.dc_leadoff_enable == DCLO_CARDIAC)
                                  & (st_nxt.gen.leadoff_current_magnitude != LEADOFF_CURRENT_MAGNITUDE_OFF)
                                  & (st_nxt.gen.leadoff_current_magnitude <= LEADOFF_CURRENT_MAGNITUDE_MAX);

    // lead-off flags pass only with their channel active
    st_nxt.flags.impedance_overrange_flag  = st_nxt.gen.impedance_channel_enable
                                             & st_nxt.gen.impedance_leadoff_enable[1] & st_r.cmp_s2[2];
    st_nxt.flags.impedance_underrange_flag = st_nxt.gen.impedance_channel_enable
                                             & st_nxt.gen.impedance_leadoff_enable[0] & st_r.cmp_s2[1];
    st_nxt.flags.dc_leadoff_flag = st_nxt.gen.cardiac_channel_enable
                                   & (st_nxt.gen.dc_leadoff_enable == DCLO_CARDIAC) & st_r.cmp_s2[0];
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RESETN_IN) begin
      st_r     <= '0;
      st_r.gen <= gcid_gen_type'(GEN_RESET);
    end else if (CE_IN) begin
      st_r <= st_nxt;
    end
  end

  assign SPI_SDO_OUT          = st_r.sdo;
  assign SPI_SDO_OE_OUT       = st_r.sel_s2;
  assign CHANNEL_CTRL_OUT     = st_r.chan;
  assign EVENT_FLAGS_OUT      = st_r.flags;
  assign MASTER_TICK_OUT      = st_r.mtick;
  assign PROGRESSION_TICK_OUT = st_r.ptick;
  assign SYNC_RESTART_OUT     = st_r.sync_pulse;

  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!RESETN_IN);

  sequence gen_write_end;
    CE_IN && end_now && !wr_rw && wr_addr == ADDR_GENERAL;
  endsequence

  sequence sync_due;
    CE_IN && st_r.sync_pend && tick_now;
  endsequence

  chk_id_pattern_rev: assert property ((addr_now == ADDR_IDENTITY && st_r.init_done)
    |-> read_word[23:20] == ID_PATTERN && read_word[19:16] == SILICON_REVISION)
    else $error("identity pattern or revision wrong");
  chk_id_dontcare_zero: assert property (addr_now == ADDR_IDENTITY
    |-> read_word[11:0] == 12'h000 && read_word[15:14] == 2'h0)
    else $error("identity don't-care bits not zero");
  chk_first_read_invalid: assert property ((addr_now == ADDR_IDENTITY && !st_r.init_done)
    |-> read_word == 24'h00_0000)
    else $error("identity valid before first command");
  chk_general_write: assert property (gen_write_end |=> st_r.gen == $past(wr_masked))
    else $error("general word not stored as masked");
  chk_ulp_state: assert property (CHANNEL_CTRL_OUT.lowpower_mode
    |-> !CHANNEL_CTRL_OUT.cardiac_on && !CHANNEL_CTRL_OUT.impedance_on)
    else $error("low power with a channel enabled");
  chk_leadon_suspend: assert property (CHANNEL_CTRL_OUT.leadon_detect_on
    |-> !CHANNEL_CTRL_OUT.cardiac_on && st_r.gen.lowpower_leadon_enable == ULP_CARDIAC)
    else $error("lead-on detect active wrongly");
  chk_master_full: assert property ((CE_IN && src_edge && st_r.gen.master_timing_select == MSTR_32768)
    |=> MASTER_TICK_OUT)
    else $error("full rate master tick missing");
  chk_pace_gate: assert property (CHANNEL_CTRL_OUT.pace_on |-> CHANNEL_CTRL_OUT.cardiac_on)
    else $error("pace on without cardiac");
  chk_prog_gate: assert property (PROGRESSION_TICK_OUT |-> $past(st_r.gen.cardiac_channel_enable))
    else $error("progression tick with cardiac off");
  chk_over_gate: assert property (EVENT_FLAGS_OUT.impedance_overrange_flag
    |-> CHANNEL_CTRL_OUT.impedance_on && st_r.gen.impedance_leadoff_enable[1])
    else $error("over-range flag not gated");
  chk_dc_gate: assert property (EVENT_FLAGS_OUT.dc_leadoff_flag
    |-> CHANNEL_CTRL_OUT.cardiac_on && st_r.gen.dc_leadoff_enable == DCLO_CARDIAC)
    else $error("dc lead-off flag not gated");
  chk_current_connect: assert property (CHANNEL_CTRL_OUT.leadoff_connect
    |-> CHANNEL_CTRL_OUT.leadoff_current_magnitude inside {[3'h1:3'h5]})
    else $error("lead-off current connected on bad code");
  chk_sync_restart: assert property (sync_due |=> SYNC_RESTART_OUT && st_r.prog_cnt == 8'h00)
    else $error("synchronize restart missed");

endmodule : gcid_regs

/* File: gcid_pkg.sv */
// gcid_pkg: register map, field layout, timing ratios and carrier types
// for the identity and general configuration register pair.
// assumes: one 50 MHz system clock, serial port pins asynchronous, synchronized in two stages.
package gcid_pkg;

  // register addresses on the serial port
  localparam logic [6:0]  ADDR_SW_RESET   = 7'h08;
  localparam logic [6:0]  ADDR_SYNC       = 7'h09;
  localparam logic [6:0]  ADDR_IDENTITY   = 7'h0F;
  localparam logic [6:0]  ADDR_GENERAL    = 7'h10;

  // identity word fields
  localparam logic [3:0]  ID_PATTERN      = 4'h5;
  localparam logic [11:0] ID_LOW_ZERO     = 12'h000;

  // general word: writable bits, power-up value
  localparam logic [23:0] GEN_WRITE_MASK  = 24'hFE_FF00;
  localparam logic [23:0] GEN_RESET       = 24'h00_0000;

  // field codes
  localparam logic [1:0]  ULP_CARDIAC     = 2'h1;
  localparam logic [1:0]  DCLO_CARDIAC    = 2'h1;
  localparam logic [2:0]  LEADOFF_CURRENT_MAGNITUDE_OFF        = 3'h0;
  localparam logic [2:0]  LEADOFF_CURRENT_MAGNITUDE_MAX        = 3'h5;
  localparam logic [1:0]  MSTR_32768      = 2'h0;
  localparam logic [1:0]  MSTR_32000_500  = 2'h1;
  localparam logic [1:0]  MSTR_32000_200  = 2'h2;

  // master clock = source_clock_32k * num / den
  localparam logic [7:0]  RATIO_FULL      = 8'h01;
  localparam logic [7:0]  RATIO_32000_NUM = 8'h7D;
  localparam logic [7:0]  RATIO_32000_DEN = 8'h80;
  localparam logic [7:0]  RATIO_31968_NUM = 8'h28;
  localparam logic [7:0]  RATIO_31968_DEN = 8'h29;

  // master ticks per cardiac progression (512/500 Hz and 200/199.8 Hz)
  localparam logic [7:0]  PROG_DIV_FAST   = 8'h40;
  localparam logic [7:0]  PROG_DIV_SLOW   = 8'hA0;

  // serial frame: 8 address bits then 24 data bits
  localparam logic [5:0]  LAST_ADDR_BIT   = 6'h07;
  localparam logic [5:0]  LAST_FRAME_BIT  = 6'h1F;

  typedef enum logic [1:0] {SPI_IDLE, SPI_ADDR, SPI_DATA, SPI_DONE} gcid_phase_type;

  typedef struct packed {
    logic [1:0] lowpower_leadon_enable;
    logic [1:0] master_timing_select;
    logic       cardiac_channel_enable;
    logic       impedance_channel_enable;
    logic       pace_channel_enable;
    logic       unused_bit;
    logic [1:0] impedance_leadoff_enable;
    logic [1:0] dc_leadoff_enable;
    logic       leadoff_current_polarity;
    logic [2:0] leadoff_current_magnitude;
    logic [7:0] low_byte;
  } gcid_gen_type;

  typedef struct packed {
    logic       cardiac_on;
    logic       impedance_on;
    logic       pace_on;
    logic       lowpower_mode;
    logic       leadon_detect_on;
    logic [1:0] master_timing_select;
    logic       leadoff_current_polarity;
    logic [2:0] leadoff_current_magnitude;
    logic       leadoff_connect;
  } gcid_chan_type;

  typedef struct packed {
    logic impedance_overrange_flag;
    logic impedance_underrange_flag;
    logic dc_leadoff_flag;
  } gcid_flag_type;

endpackage : gcid_pkg

/* File: gcid_host.sv */
// gcid_host: serial port host that frames 32-bit commands for the register pair.
// assumes: called from the bench, one CLOCK_IN domain, drives on falling edges.
module gcid_host (
  input  wire logic clock_in,   // 50 MHz system clock
  input  wire logic sdo_in,     // serial data from the device
  output logic      csb_n_out,  // chip select, active low
  output logic      sclk_out,   // serial clock, idles low
  output logic      sdi_out     // serial data to the device
);
  timeunit 1ns;
  timeprecision 1ps;
  import gcid_pkg::*;

  initial begin
    csb_n_out = 1'b1;
    sclk_out  = 1'b0;
    sdi_out   = 1'b0;
  end

  // one frame: address, read flag, 24 data bits, msb first; sclk phases 6 cycles
  task automatic xfer(input logic [6:0] addr, input logic rd, input logic [23:0] wdata,
                      output logic [23:0] rdata);
    logic [31:0] frame;
    frame = {addr, rd, wdata};
    rdata = 24'h00_0000;
    @(negedge clock_in);
    csb_n_out = 1'b0;
    repeat (4) @(negedge clock_in);
    for (int k = 31; k >= 0; k--) begin
      sclk_out = 1'b0;
      sdi_out  = frame[k];
      repeat (6) @(negedge clock_in);
      if (k < 24) rdata[k] = sdo_in;
      sclk_out = 1'b1;
      repeat (6) @(negedge clock_in);
    end
    csb_n_out = 1'b1;
    // released data line shows the inverse of its last bit
    sdi_out = ~sdi_out;
    repeat (2) @(negedge clock_in);
    sclk_out = 1'b0;
    repeat (6) @(negedge clock_in);
  endtask : xfer

  // general write followed by the restart command to realign timing
  task automatic config_gen(input logic [23:0] word);
    logic [23:0] dummy;
    xfer(ADDR_GENERAL, 1'b0, word, dummy);
    xfer(ADDR_SYNC, 1'b0, 24'h00_0000, dummy);
  endtask : config_gen
endmodule : gcid_host

/* File: gcid_regs_tb.sv */
// gcid_regs_tb: self-checking bench for the identity and general configuration pair.
// assumes: gcid_host model on the serial port, source clock made here in bursts.
module gcid_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import gcid_pkg::*;

  localparam logic [23:0] ID_EXP = 24'h56_2000;
  logic          clock = 1'b0;
  logic          resetn = 1'b0;
  logic          src = 1'b0;
  logic          over_cmp = 1'b0;
  logic          under_cmp = 1'b0;
  logic          dc_cmp = 1'b0;
  logic          csb_n, sclk, sdi, sdo, sdo_oe, tick, prog, restart;
  logic [23:0]   rd;
  gcid_chan_type chan;
  gcid_flag_type flags;
  int            n_errors = 0;
  int            samples_checked = 0;
  int            n_tick = 0;
  int            n_prog = 0;
  int            n_sync = 0;

  always #10 clock = ~clock;

  gcid_regs #(.SILICON_REVISION(4'h6), .PART_IDENT(2'h2)) dut (  // arbitrary values
    .CLOCK_IN(clock), .RESETN_IN(resetn), .CE_IN(1'b1), .SPI_CSB_N_IN(csb_n), .SPI_SCLK_IN(sclk),
    .SPI_SDI_IN(sdi), .SPI_SDO_OUT(sdo), .SPI_SDO_OE_OUT(sdo_oe), .SOURCE_CLOCK_32K_IN(src),
    .IMP_OVER_CMP_IN(over_cmp), .IMP_UNDER_CMP_IN(under_cmp), .DC_LEADOFF_CMP_IN(dc_cmp),
    .CHANNEL_CTRL_OUT(chan), .EVENT_FLAGS_OUT(flags), .MASTER_TICK_OUT(tick),
    .PROGRESSION_TICK_OUT(prog), .SYNC_RESTART_OUT(restart));

  gcid_host host (.clock_in(clock), .sdo_in(sdo), .csb_n_out(csb_n), .sclk_out(sclk), .sdi_out(sdi));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // pulses are sampled mid-cycle, away from the edge that launches them
  always @(negedge clock) begin
    if (tick === 1'b1) n_tick++;
    if (prog === 1'b1) n_prog++;
    if (restart === 1'b1) begin
      n_sync++;
      check(tick, 1'b1);
    end
  end

  function automatic gcid_chan_type chan_of(input logic [23:0] w);
    gcid_chan_type c;
    c.cardiac_on = w[19];
    c.impedance_on = w[18];
    c.pace_on = w[17] & w[19];
    c.lowpower_mode = ~w[19] & ~w[18];
    c.leadon_detect_on = ~w[19] & (w[23:22] == 2'h1);
    c.master_timing_select = w[21:20];
    c.leadoff_current_polarity = w[11];
    c.leadoff_current_magnitude = w[10:8];
    c.leadoff_connect = w[19] & (w[13:12] == 2'h1) & (w[10:8] != 3'h0) & (w[10:8] <= 3'h5);
    return c;
  endfunction : chan_of

  task automatic pulses(input int n);
    repeat (n) begin
      src = 1'b1;
      repeat (10) @(negedge clock);
      src = 1'b0;
      repeat (10) @(negedge clock);
    end
  endtask : pulses

  task automatic t_ident();
    check(chan, chan_of(24'h00_0000));
    check(sdo_oe, 1'b0);
    fork
      host.xfer(ADDR_IDENTITY, 1'b1, 24'h00_0000, rd);
      begin
        repeat (20) @(negedge clock);
        check(sdo_oe, 1'b1);
      end
    join
    check(sdo_oe, 1'b0);
    check(rd, 24'h00_0000);
    host.xfer(ADDR_IDENTITY, 1'b0, 24'hFF_FFFF, rd);
    host.xfer(ADDR_IDENTITY, 1'b1, 24'h00_0000, rd);
    check(rd, ID_EXP);
    host.xfer(7'h1F, 1'b1, 24'h00_0000, rd);
    check(rd, 24'h00_0000);
  endtask : t_ident

  task automatic t_channels();
    logic [23:0] vec[9] = '{24'h40_0000, 24'h48_0000, 24'h06_0000, 24'h0A_1D00, 24'h08_1600,
                            24'h08_2100, 24'hC0_0000, 24'h30_0000, 24'hFF_FFFF};
    foreach (vec[i]) begin
      host.xfer(ADDR_GENERAL, 1'b0, vec[i], rd);
      host.xfer(ADDR_GENERAL, 1'b1, 24'h00_0000, rd);
      check(rd, vec[i] & 24'hFE_FF00);
      check(chan, chan_of(vec[i]));
    end
  endtask : t_channels

  task automatic t_flags();
    over_cmp = 1'b1;
    under_cmp = 1'b1;
    dc_cmp = 1'b1;
    for (int b = 0; b < 4; b++) begin
      host.xfer(ADDR_GENERAL, 1'b0, {4'h0, 4'hC, 2'(b), 2'h1, 12'h000}, rd);
      check(flags, {b[1], b[0], 1'b1});
    end
    host.xfer(ADDR_GENERAL, 1'b0, 24'h00_D000, rd);
    check(flags, 3'h0);
    over_cmp = 1'b0;
    under_cmp = 1'b0;
    dc_cmp = 1'b0;
  endtask : t_flags

  task automatic t_timing();
    int t0;
    int edges[4] = '{128, 128, 128, 41};
    int ticks[4] = '{128, 125, 125, 40};
    for (int c = 0; c < 4; c++) begin
      host.config_gen({2'h0, 2'(c), 20'h0_0000});
      pulses(100);
      t0 = n_tick;
      pulses(edges[c]);
      check(n_tick - t0, ticks[c]);
    end
    host.config_gen(24'h08_0000);
    pulses(100);
    t0 = n_prog;
    pulses(128);
    check(n_prog - t0, 2);
    // slow progression: restart tick, then one pulse 160 ticks later
    host.config_gen(24'h28_0000);
    t0 = n_prog;
    pulses(250);
    check(n_prog - t0, 1);
    host.config_gen(24'h00_0000);
    t0 = n_prog;
    pulses(128);
    check(n_prog - t0, 0);
  endtask : t_timing

  task automatic t_sync();
    int t0;
    host.xfer(ADDR_SYNC, 1'b0, 24'h00_0001, rd);
    t0 = n_sync;
    pulses(8);
    check(n_sync - t0, 0);
    host.xfer(ADDR_SYNC, 1'b0, 24'h00_0000, rd);
    pulses(8);
    check(n_sync - t0, 1);
  endtask : t_sync

  task automatic t_swreset();
    host.xfer(ADDR_GENERAL, 1'b0, 24'h4B_1A00, rd);
    host.xfer(ADDR_SW_RESET, 1'b0, 24'h00_0000, rd);
    host.xfer(ADDR_IDENTITY, 1'b1, 24'h00_0000, rd);
    check(rd, 24'h00_0000);
    host.xfer(ADDR_GENERAL, 1'b1, 24'h00_0000, rd);
    check(rd, 24'h00_0000);
    check(chan, chan_of(24'h00_0000));
    host.xfer(ADDR_IDENTITY, 1'b1, 24'h00_0000, rd);
    check(rd, ID_EXP);
  endtask : t_swreset

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (8) @(negedge clock);
    resetn = 1'b1;
    repeat (3) @(negedge clock);
    t_ident();
    t_channels();
    t_flags();
    t_timing();
    t_sync();
    t_swreset();
    tally_and_finish();
  end

  // hang guard
  initial begin
    repeat (90000) @(posedge clock);
    n_errors++;
    tally_and_finish();
  end
endmodule : gcid_regs_tb
